//--- rtl/ctu_defs.svh
// constants of the trigger unit result, flag and enable bank
`ifndef CTU_DEFS_SVH
`define CTU_DEFS_SVH
// ==========================================
// fifo geometry
`define FIFO_DEPTH 8
`define PTR_W 3
`define LVL_W 4
`define RES_W 10
`define TAG_W 5
`define TH_W 8
// ==========================================
// register byte addresses
`define A_TH 8'h00
`define A_FST 8'h04
`define A_EFR 8'h08
`define A_IFR 8'h0C
`define A_IR 8'h10
`define A_FIEN 8'h14
`define A_FDE 8'h18
`define A_FR0 8'h20
`define A_FL0 8'h30
`define A_END 8'h40
// ==========================================
// field positions
`define FST_FULL 0
`define FST_EMP 1
`define FST_OF 2
`define FST_OR 3
`define FST_OR_MASK 16'h8888
`define IR_IEE 0
`define IR_MRSIE 1
`define IR_DMAE 2
`define IR_T0 3
`define IF_MRS 0
`define IF_T0 1
`define IF_ADC 9
// ==========================================
// reset values
`define RST_TH 32'h00000000
`define RST_16 16'h0000
`define RST_IR 11'h000
`define RST_FDE 4'h0
`endif

//--- rtl/ctu_pkg.sv
// types of the trigger unit result, flag and enable bank
package ctu_pkg;
`include "ctu_defs.svh"
  typedef struct packed
  {
    logic ext_trig;
    logic timer1;
    logic timer0;
    logic adc_cmd;
    logic seq_ovr;
    logic mrs_ovr;
    logic inv_cmd;
    logic seq_excess;
    logic mrs_fault;
  } err_t;
  typedef struct packed
  {
    logic [`TAG_W-1:0] tag;
    logic [`RES_W-1:0] data;
  } res_t;
  typedef struct packed
  {
    logic valid;
    logic [1:0] fifo;
    res_t res;
  } push_t;
  typedef struct packed
  {
    res_t [3:0][`FIFO_DEPTH-1:0] mem;
    logic [3:0][`PTR_W-1:0] rp;
    logic [3:0][`PTR_W-1:0] wp;
    logic [3:0][`LVL_W-1:0] lvl;
    logic [31:0] th;
    logic [15:0] fifo_status;
    err_t efr;
    logic [9:0] ifr;
    logic [10:0] ien;
    logic [15:0] fien;
    logic [3:0] fde;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic pop_ok;
    logic irq_trig;
    logic irq_mrs;
    logic irq_cmd;
    logic irq_err;
    logic irq_fifo;
    logic dma_mrs;
    logic [3:0] dma_fifo;
  } state_t;
endpackage

//--- rtl/ctu_status_bank.sv
// result fifos, error and interrupt flags, enables of the trigger unit
//
// Design decisions made here: the placing of the registers and the APB slave port.
`timescale 1ns/10ps
`include "ctu_defs.svh"
// How it works
// R01 - each fifo has own threshold; limit-exceeded flag sets when level passes it
// R02 - overrun flag sets on push into full fifo; reading it clears it
// R03 - drained flag sets when fifo becomes empty
// R04 - filled flag sets when fifo becomes full
// R05 - each result carries 5-bit source tag; msb 1 first converter, 0 second
// R06 - each fifo read through right-aligned and signed left-aligned views, same tag
// R07 - external trigger overrun error flag
// R08 - separate timer 1 and timer 0 trigger overrun error flags
// R09 - converter command generation overrun error flag
// R10 - sequencer overrun in sequential mode error flag
// R11 - more than 8 events in one sequential cycle error flag
// R12 - master reload arriving while previous unserviced sets error flag
// R13 - master reload fault sets its own error flag
// R14 - command interrupt flag sets when an interrupting command issues
// R15 - eight trigger interrupt flags, one per trigger
// R16 - master reload interrupt flag sets on each reload
// R17 - per-trigger interrupt enable gates its request
// R18 - reload dma request when its enable and general reload enable set
// R19 - reload interrupt request only while its enable is 1
// R20 - one error enable gates all error flags onto a request
// R21 - per-fifo enables for overrun, limit, drained, filled flags
// R22 - per-fifo dma enable requests service while data waits
// R23 - general reload enable qualifies reload dma requests
// R24 - other flags sticky until software writes one; set beats clear
// R25 - reading a data view of a non-empty fifo pops the oldest entry and updates status
module ctu_status_bank
  import ctu_pkg::*;
(
  // clock, reset, enable
  input wire logic pclk,
  input wire logic presetn,
  input wire logic clk_en,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // converter results and unit events
  input wire push_t result_push,
  input wire err_t err_event,
  input wire logic [7:0] trigger_event,
  input wire logic cmd_irq_event,
  input wire logic master_reload_signal,
  input wire logic general_reload_enable,
  // requests
  output logic irq_trigger,
  output logic irq_master_reload,
  output logic irq_cmd,
  output logic irq_error,
  output logic irq_fifo,
  output logic dma_master_reload,
  output logic [3:0] dma_fifo
);

  // ==========================================
  // address decode
  function automatic logic is_view(input logic [7:0] a, input logic [1:0] i);
    logic [7:0] off;
    off = {4'h0, i, 2'b00};
    return (a == (`A_FR0 + off)) || (a == (`A_FL0 + off));
  endfunction

  function automatic logic is_mapped(input logic [7:0] a);
    return (a[1:0] == 2'b00) && ((a <= `A_FDE) || ((a >= `A_FR0) && (a < `A_END)));
  endfunction

  // ==========================================
  // state
  state_t s_r;
  state_t s_nxt;

  logic setup;
  logic acc;
  logic [1:0] vidx;
  res_t head;
  logic [31:0] rv;
  logic push;
  logic pop;
  logic take;
  logic ovr;
  logic [`LVL_W-1:0] lvl_n;
  logic [15:0] fst_set;
  logic [15:0] fst_clr;
  err_t efr_clr;
  logic [9:0] ifr_set;
  logic [9:0] ifr_clr;

  always_comb
  begin
    s_nxt = s_r;
    setup = psel & ~penable;
    acc = psel & penable & s_r.pready;
    vidx = paddr[3:2];
    head = s_r.mem[vidx][s_r.rp[vidx]];
    fst_set = `RST_16;
    fst_clr = `RST_16;
    efr_clr = '0;
    ifr_clr = 10'h000;
    push = 1'b0;
    pop = 1'b0;
    take = 1'b0;
    ovr = 1'b0;
    lvl_n = '0;
    // read value mux, captured in the setup cycle so prdata comes from a flop
    case (paddr)
      `A_TH: rv = s_r.th;
      `A_FST: rv = {16'h0000, s_r.fifo_status};
      `A_EFR: rv = {23'h000000, s_r.efr};
      `A_IFR: rv = {22'h000000, s_r.ifr};
      `A_IR: rv = {21'h000000, s_r.ien};
      `A_FIEN: rv = {16'h0000, s_r.fien};
      `A_FDE: rv = {28'h0000000, s_r.fde};
      default:
      begin
        if (paddr[7:4] == 4'h2)
          rv = {11'h000, head.tag, 6'h00, head.data}; // R06 R05
        else if (paddr[7:4] == 4'h3)
          rv = {11'h000, head.tag, 1'b0, head.data, 5'h00}; // R06 R05
        else
          rv = 32'h00000000;
      end
    endcase
    s_nxt.pready = setup;
    if (setup)
    begin
      s_nxt.prdata = (pwrite || !is_mapped(paddr)) ? 32'h00000000 : rv;
      s_nxt.pslverr = !is_mapped(paddr);
      // an empty fifo read returns stale data and must not move the pointer
      s_nxt.pop_ok = (s_r.lvl[vidx] != '0);
    end
    // ==========================================
    // result fifos
    for (int i = 0; i < 4; i++)
    begin
      push = result_push.valid && (result_push.fifo == i[1:0]);
      pop = acc && !pwrite && !s_r.pslverr && is_view(paddr, i[1:0]) && s_r.pop_ok; // R25
      take = push && ((s_r.lvl[i] != `LVL_W'(`FIFO_DEPTH)) || pop);
      ovr = push && !take; // R02
      if (take)
      begin
        s_nxt.mem[i][s_r.wp[i]] = result_push.res; // R05
        s_nxt.wp[i] = s_r.wp[i] + `PTR_W'(1);
      end
      if (pop)
        s_nxt.rp[i] = s_r.rp[i] + `PTR_W'(1); // R25
      lvl_n = s_r.lvl[i] + `LVL_W'(take) - `LVL_W'(pop);
      s_nxt.lvl[i] = lvl_n;
      fst_set[4*i+`FST_OR] = ovr; // R02
      fst_set[4*i+`FST_FULL] = take && !pop && (lvl_n == `LVL_W'(`FIFO_DEPTH)); // R04
      fst_set[4*i+`FST_EMP] = pop && !take && (lvl_n == '0); // R03
      fst_set[4*i+`FST_OF] = take && !pop && ({4'h0, lvl_n} > s_r.th[`TH_W*i +: `TH_W]); // R01
    end
    // ==========================================
    // register writes and read side effects
    if (acc && pwrite && !s_r.pslverr)
    begin
      case (paddr)
        `A_TH: s_nxt.th = pwdata; // R01
        `A_FST: fst_clr = pwdata[15:0] & ~`FST_OR_MASK; // R24
        `A_EFR: efr_clr = pwdata[8:0]; // R24
        `A_IFR: ifr_clr = pwdata[9:0]; // R24
        `A_IR: s_nxt.ien = pwdata[10:0]; // R17
        `A_FIEN: s_nxt.fien = pwdata[15:0]; // R21
        `A_FDE: s_nxt.fde = pwdata[3:0]; // R22
        default: s_nxt.th = s_r.th;
      endcase
    end
    // only the overrun bits software actually saw are cleared by the read
    if (acc && !pwrite && (paddr == `A_FST))
      fst_clr = s_r.prdata[15:0] & `FST_OR_MASK; // R02
    s_nxt.fifo_status = (s_r.fifo_status & ~fst_clr) | fst_set; // R24
    // ==========================================
    // unit flags, set beats clear
    s_nxt.efr = (s_r.efr & ~efr_clr) | err_event; // R07 R08 R09 R10 R11 R12 R13 R24
    ifr_set = {cmd_irq_event, trigger_event, master_reload_signal}; // R14 R15 R16
    s_nxt.ifr = (s_r.ifr & ~ifr_clr) | ifr_set; // R24
    // ==========================================
    // requests
    s_nxt.irq_trig = |(s_nxt.ifr[`IF_T0 +: 8] & s_nxt.ien[`IR_T0 +: 8]); // R17
    s_nxt.irq_mrs = s_nxt.ifr[`IF_MRS] & s_nxt.ien[`IR_MRSIE]; // R19
    s_nxt.irq_cmd = s_nxt.ifr[`IF_ADC]; // R14
    s_nxt.irq_err = (|s_nxt.efr) & s_nxt.ien[`IR_IEE]; // R20
    s_nxt.irq_fifo = |(s_nxt.fifo_status & s_nxt.fien); // R21
    s_nxt.dma_mrs = master_reload_signal & s_r.ien[`IR_DMAE] & general_reload_enable; // R18 R23
    for (int i = 0; i < 4; i++)
      s_nxt.dma_fifo[i] = s_nxt.fde[i] & (s_nxt.lvl[i] != '0); // R22
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      s_r <= '0;
      s_r.th <= `RST_TH;
      s_r.fifo_status <= `RST_16;
      s_r.fien <= `RST_16;
      s_r.ien <= `RST_IR;
      s_r.fde <= `RST_FDE;
    end
    else if (clk_en)
      s_r <= s_nxt;
  end

  assign prdata = s_r.prdata;
  assign pready = s_r.pready;
  assign pslverr = s_r.pslverr;
  assign irq_trigger = s_r.irq_trig;
  assign irq_master_reload = s_r.irq_mrs;
  assign irq_cmd = s_r.irq_cmd;
  assign irq_error = s_r.irq_err;
  assign irq_fifo = s_r.irq_fifo;
  assign dma_master_reload = s_r.dma_mrs;
  assign dma_fifo = s_r.dma_fifo;

endmodule // ctu_status_bank

//--- sim/ctu_adc_model.sv
// converter-side model that hands results to the status bank
`timescale 1ns/10ps
module ctu_adc_model
  import ctu_pkg::*;
(
  input wire logic pclk,
  output push_t result_push
);
  initial result_push = '0;
  // one-cycle pulse, then a free cycle before the next result
  task automatic send(input logic [1:0] f, input res_t r);
    @(posedge pclk);
    result_push <= '{1'b1, f, r};
    @(posedge pclk);
    result_push <= '0;
  endtask
endmodule // ctu_adc_model

//--- sim/ctu_status_bank_chk.sv
// port assertions of the trigger unit status bank
`timescale 1ns/10ps
module ctu_status_bank_chk
(
  // clock, reset, enable
  input wire logic pclk,
  input wire logic presetn,
  input wire logic clk_en,
  // apb
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic pready,
  // events and requests
  input wire logic cmd_irq_event,
  input wire logic master_reload_signal,
  input wire logic general_reload_enable,
  input wire logic irq_master_reload,
  input wire logic irq_cmd,
  input wire logic irq_error,
  input wire logic dma_master_reload
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic wacc;
  // flags other than the fifo overrun flags, and enables, may only drop on a register write
  assign wacc = psel && penable && pwrite && pready;
  a_setup_answer: assert property (psel && !penable && clk_en |=> pready) else $error("no apb answer");
  a_ready_single: assert property (pready && clk_en |=> !pready) else $error("pready stuck");
  a_cmd_set: assert property (cmd_irq_event && clk_en |=> irq_cmd) else $error("cmd flag not set");
  a_cmd_sticky: assert property (irq_cmd && !wacc |=> irq_cmd) else $error("cmd flag lost");
  a_err_sticky: assert property (irq_error && !wacc |=> irq_error) else $error("error request lost");
  a_reload_dma: assert property (dma_master_reload |-> $past(master_reload_signal) && $past(general_reload_enable))
    else $error("reload dma without cause");
  a_dma_single: assert property (dma_master_reload && !master_reload_signal |=> !dma_master_reload)
    else $error("reload dma too long");
  a_reload_irq: assert property ($rose(irq_master_reload) |-> $past(master_reload_signal) || $past(wacc))
    else $error("reload request without cause");
  c_cmd_raised: cover property ($rose(irq_cmd));
  c_reload_dma: cover property (dma_master_reload);
  c_err_clear: cover property ($fell(irq_error));
endmodule // ctu_status_bank_chk
bind ctu_status_bank ctu_status_bank_chk i_chk
(
  .pclk(pclk),
  .presetn(presetn),
  .clk_en(clk_en),
  .psel(psel),
  .penable(penable),
  .pwrite(pwrite),
  .pready(pready),
  .cmd_irq_event(cmd_irq_event),
  .master_reload_signal(master_reload_signal),
  .general_reload_enable(general_reload_enable),
  .irq_master_reload(irq_master_reload),
  .irq_cmd(irq_cmd),
  .irq_error(irq_error),
  .dma_master_reload(dma_master_reload)
);

//--- sim/tb.sv
// self-checking bench of the trigger unit status bank
`timescale 1ns/10ps
`include "ctu_defs.svh"
module tb
  import ctu_pkg::*;
;
  logic pclk = 0, presetn = 0, clk_en = 1, psel = 0, penable = 0, pwrite = 0;
  logic master_reload_signal = 0, cmd_irq_event = 0, general_reload_enable = 0;
  logic [7:0] paddr = '0, trigger_event = '0;
  logic [31:0] pwdata = '0, prdata, q;
  logic pready, pslverr, irq_trigger, irq_master_reload, irq_cmd, irq_error, irq_fifo, dma_master_reload;
  logic [3:0] dma_fifo;
  logic q_err;
  err_t err_event = '0;
  push_t result_push;
  int error_cnt = 0, compares = 0;
  initial forever #4 pclk = ~pclk;
  ctu_status_bank i_dut
  (
    .pclk(pclk),
    .presetn(presetn),
    .clk_en(clk_en),
    .psel(psel),
    .penable(penable),
    .pwrite(pwrite),
    .paddr(paddr),
    .pwdata(pwdata),
    .prdata(prdata),
    .pready(pready),
    .pslverr(pslverr),
    .result_push(result_push),
    .err_event(err_event),
    .trigger_event(trigger_event),
    .cmd_irq_event(cmd_irq_event),
    .master_reload_signal(master_reload_signal),
    .general_reload_enable(general_reload_enable),
    .irq_trigger(irq_trigger),
    .irq_master_reload(irq_master_reload),
    .irq_cmd(irq_cmd),
    .irq_error(irq_error),
    .irq_fifo(irq_fifo),
    .dma_master_reload(dma_master_reload),
    .dma_fifo(dma_fifo)
  );
  ctu_adc_model i_adc (.pclk(pclk), .result_push(result_push));
  task tally_and_finish;
    $display("compares %0d errors %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  task chk(string s, logic [31:0] v, logic [31:0] x);
    compares++;
    if (v !== x)
    begin
      error_cnt++;
      $display("CHECK FAILED %s exp %h seen %h", s, x, v);
    end
  endtask
  // apb master; read data lands in q
  task apb(logic w, logic [7:0] a, logic [31:0] d);
    int n;
    @(posedge pclk);
    {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
    @(posedge pclk);
    penable <= 1'b1;
    for (n = 0; n < 40 && pready !== 1'b1; n++)
      @(posedge pclk);
    if (n == 40)
    begin
      error_cnt++;
      tally_and_finish;
    end
    q = prdata;
    q_err = pslverr;
    {psel, penable} <= 2'b00;
  endtask
  task rdc(logic [7:0] a, logic [31:0] x, string s);
    apb(1'b0, a, '0);
    chk(s, q, x);
  endtask
  task ev(logic [7:0] t, logic m, logic c, err_t x);
    @(posedge pclk);
    {trigger_event, master_reload_signal, cmd_irq_event, err_event} <= {t, m, c, x};
    @(posedge pclk);
    {trigger_event, master_reload_signal, cmd_irq_event, err_event} <= '0;
    #1;
  endtask
  function logic [31:0] vw(logic [3:0] i, logic l);
    return l ? {11'h0, i[0], i, 1'b0, 10'h200 + 10'(i), 5'h0} : {11'h0, i[0], i, 6'h0, 10'h200 + 10'(i)};
  endfunction
  // ==========
  // scenarios
  task t_fifo;
    rdc(`A_IR, 32'h0, "ien");
    rdc(`A_FST, 32'h0, "fst");
    apb(1'b1, `A_TH, 32'h2);
    apb(1'b1, `A_FDE, 32'h1);
    apb(1'b1, `A_FIEN, 32'h1);
    // nine pushes: the ninth meets a full fifo
    for (int i = 0; i < 9; i++)
      i_adc.send(2'h0, '{{i[0], 4'(i)}, 10'h200 + 10'(i)});
    #1 chk("dma", 32'(dma_fifo), 32'h1);
    chk("irq", 32'(irq_fifo), 32'h1);
    rdc(`A_FST, 32'hD, "fst");
    rdc(`A_FST, 32'h5, "fst");
    // a refused view read must not pop, so the walk below still starts at the oldest entry
    rdc(8'h21, 32'h0, "misaligned");
    chk("slverr", 32'(q_err), 32'h1);
    for (int i = 0; i < 8; i++)
      rdc(i[0] ? `A_FL0 : `A_FR0, vw(4'(i), i[0]), "view");
    chk("slverr", 32'(q_err), 32'h0);
    #1 chk("dma", 32'(dma_fifo), 32'h0);
    rdc(`A_FST, 32'h7, "fst");
    apb(1'b1, `A_FST, 32'hF);
    rdc(`A_FST, 32'h0, "fst");
  endtask
  task t_events;
    apb(1'b1, `A_IR, 32'h47);
    general_reload_enable <= 1'b1;
    ev(8'h20, 1'b0, 1'b0, '0);
    chk("trg", 32'(irq_trigger), 32'h0);
    ev(8'h08, 1'b1, 1'b1, '0);
    chk("trg", 32'(irq_trigger), 32'h1);
    chk("mdma", 32'(dma_master_reload), 32'h1);
    chk("cmd", 32'(irq_cmd), 32'h1);
    chk("mrs", 32'(irq_master_reload), 32'h1);
    // without the general reload enable a reload must not ask for dma
    @(posedge pclk);
    general_reload_enable <= 1'b0;
    ev(8'h00, 1'b1, 1'b0, '0);
    chk("mdma", 32'(dma_master_reload), 32'h0);
    for (int i = 0; i < 9; i++)
      ev(8'h00, 1'b0, 1'b0, err_t'(9'h1 << i));
    chk("err", 32'(irq_error), 32'h1);
    rdc(`A_IFR, 32'h251, "ifr");
    rdc(`A_EFR, 32'h1FF, "efr");
    apb(1'b1, `A_IR, 32'h0);
    #1 chk("mrs", 32'(irq_master_reload), 32'h0);
    apb(1'b1, `A_EFR, 32'h1FF);
    rdc(`A_EFR, 32'h0, "efr");
  endtask
  initial
  begin
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    t_fifo;
    t_events;
    tally_and_finish;
  end
endmodule // tb
